/* rtl/ctcc_top.v */
`timescale 1ns/1ps
`include "ctcc_map.vh"

module ctcc_top #(
  parameter [15:0] TICK_DIV  = `CTCC_TICK_DIV,
  parameter [8:0]  ATR_MAX   = `CTCC_ATR_MAX_COUNT
) (
  input  wire                       clk_in,
  input  wire                       reset_in,
  input  wire [`CTCC_ADDR_W-1:0]    addr_in,
  input  wire [7:0]                 wr_data_in,
  input  wire                       wr_en_in,
  input  wire                       rd_en_in,
  output reg  [7:0]                 rd_data_out,
  input  wire                       card_io_in,
  input  wire                       session_start_in,
  output reg                        counter1_timeout_out,
  output reg                        wide_timeout_out,
  output reg                        counter1_expired_flag_out,
  output reg                        wide_counter_expired_flag_out,
  output reg                        atr_min_done_out,
  output reg                        atr_max_done_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  reg  [7:0]  timeout_mode_config_q;
  reg  [7:0]  reload_low_byte_q;
  reg  [7:0]  reload_middle_byte_q;
  reg  [7:0]  reload_high_byte_q;
  reg  [15:0] tick_pre_q;
  reg         tick_q;
  reg  [7:0]  cnt1_q;
  reg         cnt1_run_q;
  reg         cnt1_arm_q;
  reg  [23:0] cntw_q;
  reg         cntw_run_q;
  reg         cntw_retrig_q;
  reg         cntw_24_q;
  reg  [8:0]  atr_cnt_q;
  reg  [7:0]  cnt1_d;
  reg         cnt1_run_d;
  reg         cnt1_arm_d;
  reg  [23:0] cntw_d;
  reg         cntw_run_d;
  reg         cntw_retrig_d;
  reg         cntw_24_d;
  reg  [7:0]  rd_data_d;
  wire        start_bit;
  wire        cfg_wr;
  wire        stat_wr;
  wire        cnt1_term;
  wire        cntw_term;
  wire [15:0] reload16;
  wire [23:0] reload24;
  wire        cfg_wr_c1_keep;
  wire        cfg_wr_c1_arm;
  wire        cfg_wr_w16_now;
  wire        cfg_wr_w24_now;
  wire        cfg_wr_w16_start;
  wire [7:0]  timeout_stat;

  assign cfg_wr   = wr_en_in & (addr_in == `CTCC_OFS_MODE_CONFIG);
  assign stat_wr  = wr_en_in & (addr_in == `CTCC_OFS_TIMEOUT_STAT);
  assign reload16 = {reload_high_byte_q, reload_middle_byte_q};
  assign reload24 = {reload_high_byte_q, reload_middle_byte_q, reload_low_byte_q};
  assign timeout_stat = {6'h00, wide_counter_expired_flag_out, counter1_expired_flag_out};

  // decoded configuration writes
  assign cfg_wr_c1_keep   = cfg_wr & (wr_data_in == `CTCC_MODE_C1_ONLY);
  assign cfg_wr_c1_arm    = cfg_wr & (wr_data_in == `CTCC_MODE_C1_AND_W16);
  assign cfg_wr_w16_now   = cfg_wr & ((wr_data_in == `CTCC_MODE_WIDE16_NOW) |
                                      (wr_data_in == `CTCC_MODE_C1_AND_W16));
  assign cfg_wr_w24_now   = cfg_wr & (wr_data_in == `CTCC_MODE_WIDE24_NOW);
  assign cfg_wr_w16_start = cfg_wr & (wr_data_in == `CTCC_MODE_W16_ON_START);

  // terminal count: a value of one or zero expires on this tick
  assign cnt1_term = cnt1_run_q & tick_q & (cnt1_q <= 8'h01);
  assign cntw_term = cntw_run_q & tick_q &
                     (cntw_24_q ? (cntw_q <= 24'h000001) : (cntw_q[15:0] <= 16'h0001));

  ////////////////////////////////////////////////////////////////////////////////
  // card i/o start-bit detection
  ctcc_start_detect u_start_detect (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .card_io_in    (card_io_in),
    .start_bit_out (start_bit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // count tick divider
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_pre_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else if (tick_pre_q >= TICK_DIV - 16'h0001) begin
      tick_pre_q <= 16'h0000;
      tick_q     <= 1'b1;
    end else begin
      tick_pre_q <= tick_pre_q + 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      timeout_mode_config_q <= `CTCC_RST_MODE_CONFIG;
      reload_low_byte_q     <= `CTCC_RST_RELOAD;
      reload_middle_byte_q  <= `CTCC_RST_RELOAD;
      reload_high_byte_q    <= `CTCC_RST_RELOAD;
    end else if (wr_en_in) begin
      case (addr_in)
        `CTCC_OFS_MODE_CONFIG:   timeout_mode_config_q <= wr_data_in;
        `CTCC_OFS_RELOAD_LOW:    reload_low_byte_q     <= wr_data_in;
        `CTCC_OFS_RELOAD_MIDDLE: reload_middle_byte_q  <= wr_data_in;
        `CTCC_OFS_RELOAD_HIGH:   reload_high_byte_q    <= wr_data_in;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counter 1: 8-bit auto-reload
  // code 05 falls through, so counter 1 keeps its pace and reloads
  always @* begin
    cnt1_d     = cnt1_q;
    cnt1_run_d = cnt1_run_q;
    cnt1_arm_d = cnt1_arm_q;
    if (cfg_wr_c1_arm) begin
      cnt1_d     = reload_low_byte_q;
      cnt1_run_d = 1'b0;
      cnt1_arm_d = 1'b1;
    end else if (cfg_wr & ~cfg_wr_c1_keep) begin
      cnt1_run_d = 1'b0;
      cnt1_arm_d = 1'b0;
    end else if (cnt1_arm_q & start_bit) begin
      cnt1_d     = reload_low_byte_q;
      cnt1_run_d = 1'b1;
      cnt1_arm_d = 1'b0;
    end else if (cnt1_term) begin
      cnt1_d = reload_low_byte_q;
    end else if (cnt1_run_q & tick_q) begin
      cnt1_d = cnt1_q - 8'h01;
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt1_q     <= 8'h00;
      cnt1_run_q <= 1'b0;
      cnt1_arm_q <= 1'b0;
    end else begin
      cnt1_q     <= cnt1_d;
      cnt1_run_q <= cnt1_run_d;
      cnt1_arm_q <= cnt1_arm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // wide counter: 16-bit (counters 3 and 2) or 24-bit (all three)
  // a start bit outranks terminal count, so a retrigger is never lost
  always @* begin
    cntw_d        = cntw_q;
    cntw_run_d    = cntw_run_q;
    cntw_retrig_d = cntw_retrig_q;
    cntw_24_d     = cntw_24_q;
    if (cfg_wr_w16_now) begin
      cntw_d        = {8'h00, reload16};
      cntw_run_d    = 1'b1;
      cntw_retrig_d = 1'b0;
      cntw_24_d     = 1'b0;
    end else if (cfg_wr_w24_now) begin
      cntw_d        = reload24;
      cntw_run_d    = 1'b1;
      cntw_retrig_d = 1'b0;
      cntw_24_d     = 1'b1;
    end else if (cfg_wr_w16_start) begin
      cntw_run_d    = 1'b0;
      cntw_retrig_d = 1'b1;
      cntw_24_d     = 1'b0;
    end else if (cfg_wr) begin
      cntw_run_d    = 1'b0;
      cntw_retrig_d = 1'b0;
    end else if (cntw_retrig_q & start_bit) begin
      cntw_d     = {8'h00, reload16};
      cntw_run_d = 1'b1;
    end else if (cntw_term) begin
      cntw_run_d = 1'b0;
    end else if (cntw_run_q & tick_q) begin
      cntw_d = cntw_q - 24'h000001;
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cntw_q        <= 24'h000000;
      cntw_run_q    <= 1'b0;
      cntw_retrig_q <= 1'b0;
      cntw_24_q     <= 1'b0;
    end else begin
      cntw_q        <= cntw_d;
      cntw_run_q    <= cntw_run_d;
      cntw_retrig_q <= cntw_retrig_d;
      cntw_24_q     <= cntw_24_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timeout pulses and sticky flags, set wins over write-one clear
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      counter1_timeout_out          <= 1'b0;
      wide_timeout_out              <= 1'b0;
      counter1_expired_flag_out     <= 1'b0;
      wide_counter_expired_flag_out <= 1'b0;
    end else begin
      counter1_timeout_out <= cnt1_term;
      wide_timeout_out     <= cntw_term;
      if (cnt1_term)
        counter1_expired_flag_out <= 1'b1;
      else if (stat_wr & wr_data_in[`CTCC_STAT_C1_BIT])
        counter1_expired_flag_out <= 1'b0;
      if (cntw_term)
        wide_counter_expired_flag_out <= 1'b1;
      else if (stat_wr & wr_data_in[`CTCC_STAT_WIDE_BIT])
        wide_counter_expired_flag_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // answer-to-reset interval counter
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      atr_cnt_q        <= 9'h000;
      atr_min_done_out <= 1'b0;
      atr_max_done_out <= 1'b0;
    end else if (!session_start_in) begin
      atr_cnt_q        <= 9'h000;
      atr_min_done_out <= 1'b0;
      atr_max_done_out <= 1'b0;
    end else if (tick_q & !atr_max_done_out) begin
      atr_cnt_q <= atr_cnt_q + 9'h001;
      if (atr_cnt_q + 9'h001 == `CTCC_ATR_MIN_COUNT)
        atr_min_done_out <= 1'b1;
      if (atr_cnt_q + 9'h001 == ATR_MAX)
        atr_max_done_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register reads, data one cycle after the strobe
  always @* begin
    rd_data_d = 8'h00;
    if (rd_en_in) begin
      case (addr_in)
        `CTCC_OFS_MODE_CONFIG:   rd_data_d = timeout_mode_config_q;
        `CTCC_OFS_RELOAD_LOW:    rd_data_d = reload_low_byte_q;
        `CTCC_OFS_RELOAD_MIDDLE: rd_data_d = reload_middle_byte_q;
        `CTCC_OFS_RELOAD_HIGH:   rd_data_d = reload_high_byte_q;
        `CTCC_OFS_TIMEOUT_STAT:  rd_data_d = timeout_stat;
        default:                 rd_data_d = 8'h00;
      endcase
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= rd_data_d;
    end
  end

endmodule

/* rtl/ctcc_map.vh */
`ifndef CTCC_MAP_VH
`define CTCC_MAP_VH

// register offsets on the plain register port
`define CTCC_ADDR_W            4
`define CTCC_OFS_MODE_CONFIG   4'h8
`define CTCC_OFS_RELOAD_LOW    4'h9
`define CTCC_OFS_RELOAD_MIDDLE 4'ha
`define CTCC_OFS_RELOAD_HIGH   4'hb
`define CTCC_OFS_TIMEOUT_STAT  4'hc

// reset values
`define CTCC_RST_MODE_CONFIG   8'h00
`define CTCC_RST_RELOAD        8'h00

// timeout status fields
`define CTCC_STAT_C1_BIT       0
`define CTCC_STAT_WIDE_BIT     1

// configuration codes
`define CTCC_MODE_STOP_ALL     8'h00
`define CTCC_MODE_C1_ONLY      8'h05
`define CTCC_MODE_WIDE16_NOW   8'h61
`define CTCC_MODE_C1_AND_W16   8'h65
`define CTCC_MODE_WIDE24_NOW   8'h68
`define CTCC_MODE_W16_ON_START 8'h71

// answer-to-reset interval counts, in count ticks
`define CTCC_ATR_MIN_COUNT     9'h0c8
`define CTCC_ATR_MAX_COUNT     9'h180

// count tick divider default
`define CTCC_TICK_DIV          16'h0001

`endif

/* rtl/ctcc_start_detect.v */
`timescale 1ns/1ps

module ctcc_start_detect (
  input  wire clk_in,
  input  wire reset_in,
  input  wire card_io_in,
  output reg  start_bit_out
);

  reg io_meta_q;
  reg io_sync_q;
  reg io_prev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // two-flop sync, then falling edge of the idle-high line
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      io_meta_q     <= 1'b1;
      io_sync_q     <= 1'b1;
      io_prev_q     <= 1'b1;
      start_bit_out <= 1'b0;
    end else begin
      io_meta_q     <= card_io_in;
      io_sync_q     <= io_meta_q;
      io_prev_q     <= io_sync_q;
      start_bit_out <= io_prev_q & ~io_sync_q;
    end
  end

endmodule

/* tb/ctcc_card_model.sv */
`timescale 1ns/1ps
module ctcc_card_model (
  input  wire clk_in,
  input  wire send_in,
  output wire io_out
);
  // line idles high through its pull-up; a start bit holds it low
  reg [3:0] low_q = 4'h0;
  always @(posedge clk_in) begin
    if (send_in) begin
      low_q <= 4'ha;
    end else if (low_q != 4'h0) begin
      low_q <= low_q - 4'h1;
    end
  end
  assign io_out = (low_q == 4'h0);
endmodule

/* tb/ctcc_top_assertions.sv */
`timescale 1ns/1ps
module ctcc_top_assertions #(
  parameter [15:0] TICK_DIV = 16'h1,
  parameter [8:0]  ATR_MAX  = 9'h180
) (
  input wire       clk_in,
  input wire       reset_in,
  input wire [3:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire       wr_en_in,
  input wire       rd_en_in,
  input wire [7:0] rd_data_out,
  input wire       session_start_in,
  input wire       counter1_timeout_out,
  input wire       wide_timeout_out,
  input wire       counter1_expired_flag_out,
  input wire       wide_counter_expired_flag_out,
  input wire       atr_min_done_out,
  input wire       atr_max_done_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // shadow of the configuration code
  reg [7:0] cfg_q;
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_q <= 8'h00;
    end else if (wr_en_in && addr_in == 4'h8) begin
      cfg_q <= wr_data_in;
    end
  end
  sequence cfg_held(logic [7:0] v);
    (cfg_q == v) [*3];
  endsequence
  sequence cfg_rd;
    rd_en_in && addr_in == 4'h8;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  rd_idle_a: assert property (!rd_en_in |=> rd_data_out == 8'h00)
    else $error("read data not idle");
  cfg_readback_a: assert property (cfg_rd |=> rd_data_out == $past(cfg_q))
    else $error("config readback wrong");
  stop_quiet_a: assert property (cfg_held(8'h00) |-> !counter1_timeout_out && !wide_timeout_out)
    else $error("pulse while stopped");
  wide_halt_a: assert property (cfg_held(8'h05) |-> !wide_timeout_out)
    else $error("wide pulse in code 05");
  c1_halt_a: assert property ((cfg_held(8'h61) or cfg_held(8'h68) or cfg_held(8'h71))
    |-> !counter1_timeout_out) else $error("counter 1 pulse while stopped");
  wide_flag_a: assert property ($rose(wide_timeout_out) |-> ##[0:1] wide_counter_expired_flag_out)
    else $error("wide flag not set");
  c1_flag_a: assert property ($rose(counter1_timeout_out) |-> ##[0:1] counter1_expired_flag_out)
    else $error("counter 1 flag not set");
  wide_single_a: assert property (wide_timeout_out |=> !wide_timeout_out)
    else $error("wide pulse too long");
  atr_clear_a: assert property (!session_start_in |=> !atr_min_done_out && !atr_max_done_out)
    else $error("session timing not cleared");
  atr_order_a: assert property ($rose(atr_max_done_out) |-> atr_min_done_out)
    else $error("maximum before minimum");
endmodule
bind ctcc_top ctcc_top_assertions #(.TICK_DIV(TICK_DIV), .ATR_MAX(ATR_MAX)) ctcc_top_assertions_inst (
  .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
  .session_start_in(session_start_in), .counter1_timeout_out(counter1_timeout_out),
  .wide_timeout_out(wide_timeout_out), .counter1_expired_flag_out(counter1_expired_flag_out),
  .wide_counter_expired_flag_out(wide_counter_expired_flag_out),
  .atr_min_done_out(atr_min_done_out), .atr_max_done_out(atr_max_done_out));

/* tb/ctcc_top_tb.sv */
`timescale 1ns/1ps
module ctcc_top_tb;
  reg        clk_in = 1'b0;
  reg        reset_in = 1'b1;
  reg        wr_en_in = 1'b0;
  reg        rd_en_in = 1'b0;
  reg        session_start_in = 1'b0;
  reg        send = 1'b0;
  reg  [3:0] addr_in = 4'h0;
  reg  [7:0] wr_data_in = 8'h00;
  wire [7:0] rd_data_out;
  wire       card_io, c1_p, w_p, c1_f, w_f, amin, amax;
  wire [3:0] ev = {amax, amin, w_p, c1_p};
  int        error_cnt = 0, comparisons = 0, n, t;
  always #2.5 clk_in = ~clk_in;
  ctcc_top #(.TICK_DIV(16'h1), .ATR_MAX(9'h104)) ctcc_top_inst (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
    .card_io_in(card_io), .session_start_in(session_start_in),
    .counter1_timeout_out(c1_p), .wide_timeout_out(w_p), .counter1_expired_flag_out(c1_f),
    .wide_counter_expired_flag_out(w_f), .atr_min_done_out(amin), .atr_max_done_out(amax));
  ctcc_card_model ctcc_card_model_inst (.clk_in(clk_in), .send_in(send), .io_out(card_io));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic rng(input string what, input int v, input int lo, input int hi);
    chk(what, 32'(v >= lo && v <= hi), 32'h1);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1;
    chk("rd_data", 32'(rd_data_out), 32'(e));
  endtask
  task automatic wait_ev(input int which, input int lim);
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (ev[which] !== 1'b1 && n < lim);
  endtask
  task automatic sb;
    @(posedge clk_in);
    send <= 1'b1;
    @(posedge clk_in);
    send <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    for (int a = 8; a < 13; a++) rd(4'(a), 8'h00);
    rd(4'h3, 8'h00);
    wr(4'h9, 8'h5a);
    wr(4'ha, 8'ha5);
    wr(4'hb, 8'h3c);
    rd(4'h9, 8'h5a);
    rd(4'ha, 8'ha5);
    rd(4'hb, 8'h3c);
    wr(4'h8, 8'h05);
    rd(4'h8, 8'h05);
    wr(4'h8, 8'h00);
  endtask
  task automatic t_w16;
    wr(4'ha, 8'h10);
    wr(4'hb, 8'h00);
    wr(4'h8, 8'h61);
    wait_ev(1, 60);
    rng("w16_time", n, 16, 18);
    chk("w16_flags", {c1_f, w_f}, 2'b01);
    rd(4'hc, 8'h02);
    wr(4'hc, 8'h02);
    rd(4'hc, 8'h00);
    wr(4'h8, 8'h00);
  endtask
  task automatic t_w24;
    wr(4'h9, 8'h04);
    wr(4'ha, 8'h01);
    wr(4'h8, 8'h68);
    wait_ev(1, 300);
    rng("w24_time", n, 260, 262);
    wr(4'h8, 8'h00);
    wr(4'hc, 8'h03);
    wr(4'h8, 8'h68);
    wait_ev(0, 100);
    wr(4'h8, 8'h00);
    wait_ev(1, 300);
    chk("w24_stop", n, 300);
  endtask
  task automatic t_c1;
    wr(4'h9, 8'h06);
    wr(4'ha, 8'h00);
    wr(4'hb, 8'h01);
    wr(4'h8, 8'h65);
    wait_ev(0, 30);
    chk("c1_wait", n, 30);
    sb();
    wait_ev(0, 30);
    t = 32 + n;
    rng("c1_start", n, 8, 14);
    wait_ev(0, 30);
    t += n;
    rng("c1_period", n, 6, 7);
    chk("c1_flag", c1_f, 1'b1);
    wait_ev(1, 300);
    rng("w16_now", t + n, 256, 258);
    wr(4'h8, 8'h05);
    wait_ev(0, 12);
    rng("c1_on", n, 5, 7);
    wr(4'h8, 8'h00);
    wait_ev(0, 20);
    chk("c1_stop", n, 20);
    rd(4'hc, 8'h03);
    wr(4'hc, 8'h01);
    rd(4'hc, 8'h02);
  endtask
  task automatic t_71;
    wr(4'h9, 8'h01);
    wr(4'ha, 8'h20);
    wr(4'hb, 8'h00);
    wr(4'h8, 8'h71);
    wait_ev(1, 50);
    chk("w71_wait", n, 50);
    sb();
    repeat (4) @(posedge clk_in);
    wr(4'ha, 8'h08);
    wait_ev(1, 60);
    rng("w71_old", n + 6, 34, 40);
    sb();
    wait_ev(1, 40);
    rng("w71_new", n, 10, 16);
    wr(4'h8, 8'h00);
  endtask
  task automatic t_atr;
    @(posedge clk_in);
    session_start_in <= 1'b1;
    wait_ev(2, 300);
    rng("atr_min", n, 200, 202);
    wait_ev(3, 100);
    rng("atr_max", n + 200, 260, 262);
    @(posedge clk_in);
    session_start_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk("atr_clear", {amin, amax}, 2'b00);
  endtask
  task automatic t_rst;
    chk("w_flag_pre", w_f, 1'b1);
    wr(4'h9, 8'h77);
    wr(4'h8, 8'h05);
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    chk("rst_flags", {c1_f, w_f}, 2'b00);
    rd(4'h8, 8'h00);
    rd(4'h9, 8'h00);
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    t_regs();
    t_w16();
    t_w24();
    t_c1();
    t_71();
    t_atr();
    t_rst();
    final_report();
  end
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule
